// *** verilog/hct_pkg.sv ***
package hct_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_FILL = 4'h4;
  localparam logic [3:0] ADDR_CMD = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hc;

  // ----------------------------------------------------------------
  // field codes and constants
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_TMA = 2'h0;
  localparam logic [1:0] MODE_TMBR = 2'h1;
  localparam logic [1:0] MODE_RATE = 2'h2;
  localparam logic [1:0] MODE_HDLC = 2'h3;

  localparam logic [7:0] FILL_ONES = 8'hff;
  localparam logic [7:0] FILL_ZEROS = 8'h00;
  localparam logic [7:0] FILL_FLAG = 8'h7e;

  localparam logic [2:0] REP_RV0 = 3'h7;
  localparam logic [2:0] REP_RV1 = 3'h3;
  localparam logic [2:0] REP_RV2 = 3'h1;
  localparam logic [2:0] REP_RV3 = 3'h0;

  localparam logic [4:0] CNT_BYTE_LAST = 5'h07;
  localparam logic [4:0] CNT_FILL_LAST = 5'h0f;
  localparam logic [4:0] CNT_CRC16_LAST = 5'h0f;
  localparam logic [4:0] CNT_CRC32_LAST = 5'h1f;

  localparam logic [31:0] POLY_CRC32 = 32'h04c11db7;
  localparam logic [31:0] POLY_CRC16 = 32'h00001021;
  localparam logic [31:0] CRC_MASK16 = 32'h0000ffff;
  localparam logic [31:0] CRC_PRESET = 32'hffffffff;

  localparam int unsigned BIT_DIV_DEF = 20;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_FILL = 3'b001,
    ST_DATA = 3'b010,
    ST_CRC = 3'b100
  } hct_state_t;

  typedef struct packed {
    logic flag_adjust;
    logic [1:0] rate_repeat_select;
    logic data_invert;
    logic check_to_mem;
    logic crc_wide;
    logic [1:0] mode;
  } hct_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } hct_byte_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } hct_reg_req_t;

  typedef struct packed {
    hct_cfg_t cfg;
    logic [15:0] transparent_fill_pattern;
    logic tx_hold;
    logic hold_active;
    hct_state_t st;
    logic [15:0] sh;
    logic [4:0] cnt;
    logic [2:0] rep;
    logic [15:0] div;
    logic frame_open;
    logic tx_bit;
    logic bit_stb;
    logic req;
    logic rx_bit;
    logic [31:0] rdata;
  } hct_regs_t;

  typedef struct packed {
    logic [31:0] crc;
  } hct_crc_regs_t;

endpackage

// *** verilog/hct_crc.sv ***
`timescale 1ns/1ps
`default_nettype none
module hct_crc (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic init,
  input wire logic step,
  input wire logic calc,
  input wire logic din,
  input wire logic wide,
  output logic out_bit
);
  import hct_pkg::*;

  hct_crc_regs_t q_r;
  hct_crc_regs_t q_nxt;
  logic msb;
  logic [31:0] sh;

  // ----------------------------------------------------------------
  // serial crc, 16 or 32 bit
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    msb = wide ? q_r.crc[31] : q_r.crc[15];
    sh = {q_r.crc[30:0], 1'b1};
    if (init) begin
      q_nxt.crc = CRC_PRESET;
    end else if (step) begin
      if (calc && (msb ^ din)) begin
        sh = sh ^ (wide ? POLY_CRC32 : POLY_CRC16) ^ 32'h00000001;
      end else if (calc) begin
        sh = sh ^ 32'h00000001;
      end
      q_nxt.crc = wide ? sh : (sh & CRC_MASK16);
    end
    out_bit = ~msb;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// *** verilog/hct_tx_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module hct_tx_control #(
  parameter int unsigned BIT_DIV = hct_pkg::BIT_DIV_DEF
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire hct_pkg::hct_reg_req_t REG_REQ,
  output logic [31:0] REG_RDATA,
  input wire logic TXD_VALID,
  input wire hct_pkg::hct_byte_t TXD,
  output logic TXD_TAKE,
  output logic TX_BIT,
  output logic TX_STB,
  input wire logic RX_BIT_IN,
  output logic RX_BIT_OUT
);
  import hct_pkg::*;

  hct_regs_t q_r;
  hct_regs_t q_nxt;
  logic [7:0] rev;
  logic crc_init;
  logic crc_step;
  logic crc_calc;
  logic crc_din;
  logic crc_bit;
  logic bit_en;
  logic cur;
  logic [4:0] last_cnt;
  logic [2:0] rep_load;
  logic [15:0] fill16;
  logic load_next;

  localparam logic [15:0] DIV_LAST = 16'(BIT_DIV - 1);

  // ----------------------------------------------------------------
  // byte reversal, lsb of a byte leaves first
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_rev
    assign rev[i] = TXD.data[7 - i];
  end

  // ----------------------------------------------------------------
  // crc engine
  // ----------------------------------------------------------------
  hct_crc u_crc (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .init(crc_init),
    .step(crc_step),
    .calc(crc_calc),
    .din(crc_din),
    .wide(q_r.cfg.crc_wide),
    .out_bit(crc_bit)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.req = 1'b0;
    q_nxt.bit_stb = 1'b0;
    q_nxt.rdata = '0;
    crc_init = 1'b0;
    crc_step = 1'b0;
    crc_calc = 1'b0;
    crc_din = q_r.sh[15];
    load_next = 1'b0;
    bit_en = (q_r.div == DIV_LAST);
    q_nxt.div = bit_en ? '0 : q_r.div + 16'h0001;

    case (q_r.cfg.mode)
      MODE_TMA: fill16 = q_r.cfg.flag_adjust ? q_r.transparent_fill_pattern : {FILL_ONES, FILL_ONES};
      MODE_HDLC: fill16 = {FILL_FLAG, FILL_FLAG};
      default: fill16 = {FILL_ZEROS, FILL_ZEROS};
    endcase

    if (q_r.cfg.mode != MODE_RATE) begin
      rep_load = REP_RV3;
    end else begin
      case (q_r.cfg.rate_repeat_select)
        2'h0: rep_load = REP_RV0;
        2'h1: rep_load = REP_RV1;
        2'h2: rep_load = REP_RV2;
        default: rep_load = REP_RV3;
      endcase
    end

    case (q_r.st)
      ST_DATA: last_cnt = CNT_BYTE_LAST;
      ST_CRC: last_cnt = q_r.cfg.crc_wide ? CNT_CRC32_LAST : CNT_CRC16_LAST;
      default: last_cnt = CNT_FILL_LAST;
    endcase

    cur = (q_r.st == ST_CRC) ? crc_bit : q_r.sh[15];

    if (bit_en) begin
      q_nxt.tx_bit = cur ^ q_r.cfg.data_invert;
      q_nxt.bit_stb = 1'b1;
      if (q_r.rep != '0) begin
        q_nxt.rep = q_r.rep - 3'h1;
      end else begin
        q_nxt.rep = rep_load;
        q_nxt.sh = {q_r.sh[14:0], 1'b0};
        q_nxt.cnt = q_r.cnt + 5'h01;
        crc_step = (q_r.st != ST_FILL);
        crc_calc = (q_r.st == ST_DATA);
        if (q_r.cnt == last_cnt) begin
          q_nxt.cnt = '0;
          case (q_r.st)
            ST_DATA: begin
              if (q_r.frame_open) begin
                load_next = 1'b1;
              end else if ((q_r.cfg.mode == MODE_HDLC) && !q_r.cfg.check_to_mem) begin
                q_nxt.st = ST_CRC;
              end else begin
                load_next = 1'b1;
              end
            end
            default: load_next = 1'b1;
          endcase
        end
      end
    end

    if (load_next) begin
      if (!q_r.tx_hold && TXD_VALID) begin
        q_nxt.st = ST_DATA;
        q_nxt.sh = {rev, 8'h00};
        q_nxt.req = 1'b1;
        q_nxt.frame_open = !TXD.last;
        q_nxt.hold_active = 1'b0;
        crc_init = !q_r.frame_open;
      end else begin
        q_nxt.st = ST_FILL;
        q_nxt.sh = fill16;
        q_nxt.hold_active = q_r.tx_hold;
        // a fill unit ends any cut frame
        q_nxt.frame_open = 1'b0;
      end
    end

    q_nxt.rx_bit = RX_BIT_IN ^ q_r.cfg.data_invert;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    if (REG_REQ.wr) begin
      if (REG_REQ.addr == ADDR_CFG) begin
        q_nxt.cfg = REG_REQ.wdata[7:0];
      end else if (REG_REQ.addr == ADDR_FILL) begin
        q_nxt.transparent_fill_pattern = REG_REQ.wdata[15:0];
      end else if (REG_REQ.addr == ADDR_CMD) begin
        q_nxt.tx_hold = REG_REQ.wdata[0];
      end
    end
    if (REG_REQ.rd) begin
      if (REG_REQ.addr == ADDR_CFG) begin
        q_nxt.rdata = {24'h000000, q_r.cfg};
      end else if (REG_REQ.addr == ADDR_FILL) begin
        q_nxt.rdata = {16'h0000, q_r.transparent_fill_pattern};
      end else if (REG_REQ.addr == ADDR_CMD) begin
        q_nxt.rdata = {31'h00000000, q_r.tx_hold};
      end else if (REG_REQ.addr == ADDR_STAT) begin
        q_nxt.rdata = {26'h0000000, q_r.frame_open,
                       (q_r.cfg.mode == MODE_TMBR) && q_r.cfg.crc_wide,
                       q_r.hold_active, q_r.st};
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      q_r <= '0;
      q_r.st <= ST_FILL;
      q_r.sh <= {FILL_ONES, FILL_ONES};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign REG_RDATA = q_r.rdata;
  assign TXD_TAKE = q_r.req;
  assign TX_BIT = q_r.tx_bit;
  assign TX_STB = q_r.bit_stb;
  assign RX_BIT_OUT = q_r.rx_bit;
endmodule
`default_nettype wire

// *** tb/hct_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module hct_src_model (
  input wire logic clk,
  input wire logic en,
  input wire logic take,
  output logic valid,
  output hct_pkg::hct_byte_t txd
);
  import hct_pkg::*;
  logic [7:0] n_r = 8'h35;
  always_ff @(posedge clk) begin
    if (take) begin
      n_r <= n_r + 8'h4b;
    end
  end
  // a disabled source shows the inverse
  assign valid = en;
  assign txd = '{data: (en ? n_r : ~n_r), last: (en & (n_r[1:0] == 2'h2))};
endmodule
`default_nettype wire

// *** tb/hct_tx_control_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module hct_tx_control_props #(
  parameter int unsigned BIT_DIV = hct_pkg::BIT_DIV_DEF
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire hct_pkg::hct_reg_req_t REG_REQ,
  input wire logic [31:0] REG_RDATA,
  input wire logic TXD_VALID,
  input wire hct_pkg::hct_byte_t TXD,
  input wire logic TXD_TAKE,
  input wire logic TX_BIT,
  input wire logic TX_STB,
  input wire logic RX_BIT_IN,
  input wire logic RX_BIT_OUT
);
  import hct_pkg::*;
  logic [7:0] cfg_r;
  logic hold_r;
  // ----------------------------------------
  // shadow of written config and hold
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      cfg_r <= 8'h00;
      hold_r <= 1'b0;
    end else if (REG_REQ.wr && REG_REQ.addr == ADDR_CFG) begin
      cfg_r <= REG_REQ.wdata[7:0];
    end else if (REG_REQ.wr && REG_REQ.addr == ADDR_CMD) begin
      hold_r <= REG_REQ.wdata[0];
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  a_rdata_idle: assert property (!$past(REG_REQ.rd) |-> REG_RDATA == 32'h0)
    else $error("read data outside answer cycle");
  a_cfg_read: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_CFG |=> REG_RDATA[7:0] == cfg_r)
    else $error("config readback wrong");
  a_rx_invert: assert property (
    $past(RST_N) |-> RX_BIT_OUT == ($past(RX_BIT_IN) ^ $past(cfg_r[4])))
    else $error("receive bit not inverted as set");
  a_stb_period: assert property (TX_STB |-> ##BIT_DIV TX_STB)
    else $error("bit strobe period wrong");
  a_bit_stable: assert property (!TX_STB |-> $stable(TX_BIT))
    else $error("serial bit changed without strobe");
  a_hold_no_take: assert property (hold_r && $past(hold_r) |=> !TXD_TAKE)
    else $error("byte taken under hold");
  a_take_on_stb: assert property (TXD_TAKE |-> TX_STB)
    else $error("take off unit boundary");
  a_take_space: assert property (TXD_TAKE |=> !TXD_TAKE [*7])
    else $error("takes too close");
endmodule
bind hct_tx_control hct_tx_control_props #(.BIT_DIV(BIT_DIV)) u_hct_tx_control_props (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
  .TXD_VALID(TXD_VALID), .TXD(TXD), .TXD_TAKE(TXD_TAKE), .TX_BIT(TX_BIT),
  .TX_STB(TX_STB), .RX_BIT_IN(RX_BIT_IN), .RX_BIT_OUT(RX_BIT_OUT));
`default_nettype wire

// *** tb/hct_tx_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module hct_tx_control_tb;
  import hct_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  hct_reg_req_t req = '0;
  logic rx_in = 1'b0;
  logic src_en = 1'b0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic valid, take, tx_bit, tx_stb, rx_out;
  hct_byte_t txd;
  int bad_count = 0;
  int checked = 0;
  always #25 clk = ~clk;
  always @(posedge clk) rx_in <= tx_bit;
  hct_tx_control #(.BIT_DIV(2)) u_hct_tx_control (
    .REF_CLK(clk), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata), .TXD_VALID(valid),
    .TXD(txd), .TXD_TAKE(take), .TX_BIT(tx_bit), .TX_STB(tx_stb), .RX_BIT_IN(rx_in),
    .RX_BIT_OUT(rx_out));
  hct_src_model u_hct_src_model (.clk(clk), .en(src_en), .take(take), .valid(valid), .txd(txd));
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    q = rdata;
    @(posedge clk);
  endtask
  task automatic nb();
    do @(negedge clk); while (tx_stb !== 1'b1);
  endtask
  task automatic stop();
    acc(1'b1, ADDR_CMD, 32'h1, v);
    repeat (240) nb();
    acc(1'b0, ADDR_STAT, 32'h0, v);
    chk(v & 32'hf, 32'h9);
  endtask
  task automatic fill(input logic [7:0] c, input logic [31:0] ones);
    logic [31:0] n;
    n = 0;
    acc(1'b1, ADDR_CFG, {24'h0, c}, v);
    repeat (32) nb();
    repeat (16) begin
      nb();
      n = n + tx_bit;
    end
    chk(n, ones);
    $display("fill test %h done", c);
  endtask
  task automatic snd(input logic [7:0] c, input int reps);
    logic [7:0] e;
    logic [31:0] w;
    w = 0;
    acc(1'b1, ADDR_CFG, {24'h0, c}, v);
    acc(1'b1, ADDR_CMD, 32'h0, v);
    do @(negedge clk); while (take !== 1'b1);
    e = txd.data ^ {8{c[4]}};
    for (int i = 0; i < 8; i++) begin
      repeat (reps) begin
        nb();
        w = w + (tx_bit !== e[i]);
      end
    end
    chk(w, 0);
    stop();
    $display("send test %h done", c);
  endtask
  task automatic gap(input logic [7:0] c, input int crc_len);
    int n;
    logic lst;
    acc(1'b1, ADDR_CFG, {24'h0, c}, v);
    acc(1'b1, ADDR_CMD, 32'h0, v);
    do @(negedge clk); while (take !== 1'b1);
    repeat (8) begin
      lst = txd.last;
      n = 0;
      do begin
        nb();
        n++;
      end while (take !== 1'b1);
      chk(n, lst ? 8 + crc_len : 8);
    end
    stop();
    $display("frame gap test %h done", c);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    acc(1'b1, ADDR_CMD, 32'h1, v);
    acc(1'b0, ADDR_CFG, 32'h0, v);
    chk(v, 32'h0);
    acc(1'b0, ADDR_STAT, 32'h0, v);
    chk(v, 32'h1);
    acc(1'b0, 4'h2, 32'h0, v);
    chk(v, 32'h0);
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, ADDR_CFG, (m[0] ? 32'h4 : 32'h0) | m, v);
      acc(1'b0, ADDR_STAT, 32'h0, v);
      chk(v & 32'h10, (m == 1) ? 32'h10 : 32'h0);
    end
    acc(1'b1, ADDR_CFG, 32'h1, v);
    acc(1'b0, ADDR_STAT, 32'h0, v);
    chk(v & 32'h10, 32'h0);
    $display("register test done");
    acc(1'b1, ADDR_FILL, 32'h0f01, v);
    acc(1'b1, ADDR_CMD, 32'h1, v);
    src_en <= 1'b1;
    fill(8'h00, 16);
    fill(8'h01, 0);
    fill(8'h02, 0);
    fill(8'h03, 12);
    fill(8'h80, 5);
    fill(8'h10, 0);
    acc(1'b0, ADDR_STAT, 32'h0, v);
    chk(v & 32'hf, 32'h9);
    snd(8'h00, 1);
    snd(8'h10, 1);
    for (int r = 0; r < 4; r++) begin
      snd({1'b0, r[1:0], 5'h02}, 8 >> r);
    end
    gap(8'h03, 16);
    gap(8'h07, 32);
    gap(8'h0b, 0);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
